// ===== verilog/tc8_cfg.svh
// named offsets, field positions, codes and divider masks of the 8-bit timer
// assumes inclusion by bare name from the timer module and the bench
`ifndef TC8_CFG_SVH
`define TC8_CFG_SVH
// register offsets on the plain register port
`define TC8_ADDR_W       4
`define TC8_OFF_CTRLA    4'h0
`define TC8_OFF_CTRLB    4'h1
`define TC8_OFF_CNT      4'h2
`define TC8_OFF_CMPA     4'h3
`define TC8_OFF_CMPB     4'h4
`define TC8_OFF_FLAG     4'h5
`define TC8_OFF_MASK     4'h6
`define TC8_OFF_ASYNC    4'h7
// field positions
`define TC8_COMA_HI      7
`define TC8_COMA_LO      6
`define TC8_COMB_HI      5
`define TC8_COMB_LO      4
`define TC8_FOCA_BIT     7
`define TC8_FOCB_BIT     6
`define TC8_WGM2_BIT     3
`define TC8_ASYNC_BIT    5
`define TC8_BIT_OVF      0
`define TC8_BIT_MA       1
`define TC8_BIT_MB       2
`define TC8_FIELD_LO     0
`define TC8_WGML_HI      1
`define TC8_CS_HI        2
`define TC8_FLAGS_HI     2
// values
`define TC8_BOTTOM       8'h00
`define TC8_MAX          8'hff
`define TC8_ZERO8        8'h00
`define TC8_CS_OFF       3'h0
`define TC8_COM_NONE     2'h0
`define TC8_COM_TOGGLE   2'h1
`define TC8_COM_CLEAR    2'h2
`define TC8_COM_SET      2'h3
// waveform modes
`define TC8_WGM_NORMAL   3'h0
`define TC8_WGM_PCMAX    3'h1
`define TC8_WGM_CTC      3'h2
`define TC8_WGM_FASTMAX  3'h3
`define TC8_WGM_PCTOPA   3'h5
`define TC8_WGM_FASTTOPA 3'h7
// prescaler tap masks, divide by 1, 8, 32, 64, 128, 256, 1024
`define TC8_DIV1         10'h000
`define TC8_DIV8         10'h007
`define TC8_DIV32        10'h01f
`define TC8_DIV64        10'h03f
`define TC8_DIV128       10'h07f
`define TC8_DIV256       10'h0ff
`define TC8_DIV1024      10'h3ff
`define TC8_PRE_ONE      10'h001
`define TC8_CNT_ONE      8'h01
`endif

// ===== verilog/tc8_pkg.sv
// types shared by the 8-bit timer/counter
// includes nothing; the cfg header is pulled in by the module and bench
package tc8_pkg;
    typedef enum logic {TC8_UP = 1'b0, TC8_DOWN = 1'b1} tc8_dir_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tc8_req_t;

    // whole state of the timer
    typedef struct packed {
        logic [9:0] pre;
        logic [7:0] cnt;
        logic [7:0] actA;
        logic [7:0] actB;
        logic [7:0] bufA;
        logic [7:0] bufB;
        logic [1:0] comA;
        logic [1:0] comB;
        logic [2:0] wgm;
        logic [2:0] cs;
        logic       asyncSel;
        logic [2:0] flags;
        logic [2:0] mask;
        tc8_dir_t   dir;
        logic       block;
        logic       waveA;
        logic       waveB;
        logic [2:0] irq;
        logic [7:0] rdData;
        logic       oscS1;
        logic       oscS2;
        logic       oscPrev;
    } tc8_state_t;
endpackage

// ===== verilog/tc8_timer.sv
// 8-bit timer/counter with two compare channels and register port
// assumes one clock clk_sys, async active-low reset, same-domain bus master
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "tc8_cfg.svh"

module tc8_timer (
    input  wire logic       clk_sys,    // system clock, 20 MHz
    input  wire logic       arst_n,     // async reset, active low
    input  wire logic [3:0] regAddr,    // register address
    input  wire logic [7:0] regWdata,   // write data
    input  wire logic       regWr,      // write strobe
    input  wire logic       regRd,      // read strobe
    input  wire logic [2:0] intAck,     // service pulses: b, a, overflow
    input  wire logic       oscPinIn,   // low frequency oscillator pin
    output logic      [7:0] regRdata,   // read data, cycle after strobe
    output logic      [2:0] irqReq,     // interrupt requests: b, a, overflow
    output logic            waveOutA,   // compare output a
    output logic            waveOutB    // compare output b
);
    tc8_pkg::tc8_state_t stReg;
    tc8_pkg::tc8_state_t stNext;
    tc8_pkg::tc8_req_t   req;

    logic       wrCnt;
    logic       isPwm;
    logic       isFast;
    logic       isPhase;
    logic       topIsA;
    logic [7:0] topVal;
    logic [9:0] divMask;
    logic       baseTick;
    logic       tick;
    logic       matchA;
    logic       matchB;
    logic       setA;
    logic       setB;
    logic       setOvf;
    logic       atTop;
    logic [2:0] wrClr;

    // -------------------------------------------------------------
    // output action of one channel
    // -------------------------------------------------------------
    function automatic logic actOut(input logic [1:0] com, input logic cur, input logic lvl);
        logic res;
        res = cur;
        if (com == `TC8_COM_TOGGLE) begin
            res = ~cur;
        end else if (com == `TC8_COM_CLEAR) begin
            res = lvl;
        end else if (com == `TC8_COM_SET) begin
            res = ~lvl;
        end
        return res;
    endfunction

    // -------------------------------------------------------------
    // mode decode and tick source
    // -------------------------------------------------------------
    // bus request bundled once for the state logic
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
    assign wrCnt = req.wr && (req.addr == `TC8_OFF_CNT);
    assign isFast = (stReg.wgm == `TC8_WGM_FASTMAX) || (stReg.wgm == `TC8_WGM_FASTTOPA);
    assign isPhase = (stReg.wgm == `TC8_WGM_PCMAX) || (stReg.wgm == `TC8_WGM_PCTOPA);
    // reserved codes count as plain pwm so a stray write never drops buffering
    assign isPwm = (stReg.wgm != `TC8_WGM_NORMAL) && (stReg.wgm != `TC8_WGM_CTC);
    assign topIsA = (stReg.wgm == `TC8_WGM_CTC) || (stReg.wgm == `TC8_WGM_PCTOPA)
                    || (stReg.wgm == `TC8_WGM_FASTTOPA);
    assign topVal = topIsA ? stReg.actA : `TC8_MAX;
    assign atTop = (stReg.cnt == topVal);
    // async source: rising edge of the synchronised oscillator pin
    assign baseTick = stReg.asyncSel ? (stReg.oscS2 && !stReg.oscPrev) : 1'b1;

    // prescaler tap per clock select code
    always_comb begin
        unique case (stReg.cs)
            3'h1:    divMask = `TC8_DIV1;
            3'h2:    divMask = `TC8_DIV8;
            3'h3:    divMask = `TC8_DIV32;
            3'h4:    divMask = `TC8_DIV64;
            3'h5:    divMask = `TC8_DIV128;
            3'h6:    divMask = `TC8_DIV256;
            3'h7:    divMask = `TC8_DIV1024;
            default: divMask = `TC8_DIV1;
        endcase
    end

    assign tick = (stReg.cs != `TC8_CS_OFF) && baseTick && ((stReg.pre & divMask) == divMask);

    // -------------------------------------------------------------
    // compare and flag events
    // -------------------------------------------------------------
    assign matchA = (stReg.cnt == stReg.actA);
    assign matchB = (stReg.cnt == stReg.actB);
    // a pending counter write masks both channels for one tick
    assign setA = tick && matchA && !stReg.block;
    assign setB = tick && matchB && !stReg.block;
    assign setOvf = tick && (isPhase ? (stReg.dir == tc8_pkg::TC8_DOWN && stReg.cnt == `TC8_BOTTOM)
                                     : (isPwm ? atTop : stReg.cnt == `TC8_MAX));
    assign wrClr = (req.wr && req.addr == `TC8_OFF_FLAG) ? req.wdata[`TC8_FLAGS_HI:`TC8_FIELD_LO] : 3'h0;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        stNext = stReg;
        // two-stage synchroniser, only the second stage is looked at
        stNext.oscS1 = oscPinIn;
        stNext.oscS2 = stReg.oscS1;
        stNext.oscPrev = stReg.oscS2;
        if (baseTick) begin
            stNext.pre = stReg.pre + `TC8_PRE_ONE;
        end

        // counting sequence
        if (tick) begin
            if (isPhase) begin
                if (stReg.dir == tc8_pkg::TC8_UP) begin
                    if (atTop) begin
                        stNext.dir = tc8_pkg::TC8_DOWN;
                        stNext.cnt = stReg.cnt - `TC8_CNT_ONE;
                    end else begin
                        stNext.cnt = stReg.cnt + `TC8_CNT_ONE;
                    end
                end else begin
                    if (stReg.cnt == `TC8_BOTTOM) begin
                        stNext.dir = tc8_pkg::TC8_UP;
                        stNext.cnt = stReg.cnt + `TC8_CNT_ONE;
                    end else begin
                        stNext.cnt = stReg.cnt - `TC8_CNT_ONE;
                    end
                end
            end else if (topIsA || isFast) begin
                stNext.cnt = atTop ? `TC8_ZERO8 : stReg.cnt + `TC8_CNT_ONE;
            end else begin
                stNext.cnt = stReg.cnt + `TC8_CNT_ONE;
            end
            // block lasts exactly until the tick after the write
            stNext.block = 1'b0;
        end

        // buffered compare values load only at top
        if (isPwm && tick && atTop) begin
            stNext.actA = stReg.bufA;
            stNext.actB = stReg.bufB;
        end

        // output waveforms
        if (isPwm) begin
            if (setA) begin
                stNext.waveA = actOut(stReg.comA, stReg.waveA, stReg.dir == tc8_pkg::TC8_DOWN);
            end
            if (setB) begin
                stNext.waveB = actOut(stReg.comB, stReg.waveB, stReg.dir == tc8_pkg::TC8_DOWN);
            end
            if (isFast && tick && atTop) begin
                stNext.waveA = actOut(stReg.comA, stReg.waveA, 1'b1);
                stNext.waveB = actOut(stReg.comB, stReg.waveB, 1'b1);
            end
        end else begin
            if (setA || (req.wr && req.addr == `TC8_OFF_CTRLB && req.wdata[`TC8_FOCA_BIT])) begin
                stNext.waveA = actOut(stReg.comA, stReg.waveA, 1'b0);
            end
            if (setB || (req.wr && req.addr == `TC8_OFF_CTRLB && req.wdata[`TC8_FOCB_BIT])) begin
                stNext.waveB = actOut(stReg.comB, stReg.waveB, 1'b0);
            end
        end

        // flags: hardware set beats software or service clear
        stNext.flags = (stReg.flags & ~(wrClr | intAck)) | {setB, setA, setOvf};

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                `TC8_OFF_CTRLA: begin
                    stNext.comA = req.wdata[`TC8_COMA_HI:`TC8_COMA_LO];
                    stNext.comB = req.wdata[`TC8_COMB_HI:`TC8_COMB_LO];
                    stNext.wgm[1:0] = req.wdata[`TC8_WGML_HI:`TC8_FIELD_LO];
                end
                `TC8_OFF_CTRLB: begin
                    stNext.wgm[2] = req.wdata[`TC8_WGM2_BIT];
                    stNext.cs = req.wdata[`TC8_CS_HI:`TC8_FIELD_LO];
                end
                `TC8_OFF_CNT: begin
                    stNext.cnt = req.wdata;
                    stNext.block = 1'b1;
                end
                `TC8_OFF_CMPA: begin
                    stNext.bufA = req.wdata;
                    if (!isPwm) begin
                        stNext.actA = req.wdata;
                    end
                end
                `TC8_OFF_CMPB: begin
                    stNext.bufB = req.wdata;
                    if (!isPwm) begin
                        stNext.actB = req.wdata;
                    end
                end
                `TC8_OFF_MASK:  stNext.mask = req.wdata[`TC8_FLAGS_HI:`TC8_FIELD_LO];
                `TC8_OFF_ASYNC: stNext.asyncSel = req.wdata[`TC8_ASYNC_BIT];
                default: ;
            endcase
        end

        stNext.irq = stNext.flags & stNext.mask;

        // read data, valid only the cycle after the strobe
        stNext.rdData = `TC8_ZERO8;
        if (req.rd) begin
            unique case (req.addr)
                `TC8_OFF_CTRLA: stNext.rdData = {stReg.comA, stReg.comB, 2'h0, stReg.wgm[1:0]};
                `TC8_OFF_CTRLB: stNext.rdData = {4'h0, stReg.wgm[2], stReg.cs};
                `TC8_OFF_CNT:   stNext.rdData = stReg.cnt;
                `TC8_OFF_CMPA:  stNext.rdData = isPwm ? stReg.bufA : stReg.actA;
                `TC8_OFF_CMPB:  stNext.rdData = isPwm ? stReg.bufB : stReg.actB;
                `TC8_OFF_FLAG:  stNext.rdData = {5'h0, stReg.flags};
                `TC8_OFF_MASK:  stNext.rdData = {5'h0, stReg.mask};
                `TC8_OFF_ASYNC: stNext.rdData = {2'h0, stReg.asyncSel, 5'h0};
                default:        stNext.rdData = `TC8_ZERO8;
            endcase
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    assign regRdata = stReg.rdData;
    assign irqReq = stReg.irq;
    assign waveOutA = stReg.waveA;
    assign waveOutB = stReg.waveB;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_stop_frozen: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.cs == `TC8_CS_OFF && !wrCnt) |=> $stable(stReg.cnt))
        else $error("counter moved with clock select off");

    a_cnt_write_wins: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wrCnt |=> (stReg.cnt == $past(regWdata)) && stReg.block)
        else $error("counter write lost");

    a_flag_a_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (tick && matchA && !stReg.block) |=> stReg.flags[`TC8_BIT_MA])
        else $error("match a flag not set");

    a_write_blocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (wrCnt && !stReg.flags[`TC8_BIT_MB] && !setB) ##1 (tick && matchB) |=> !stReg.flags[`TC8_BIT_MB])
        else $error("match after counter write not blocked");

    a_normal_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.wgm == `TC8_WGM_NORMAL && tick && stReg.cnt == `TC8_MAX && !wrCnt)
        |=> (stReg.cnt == `TC8_BOTTOM) && stReg.flags[`TC8_BIT_OVF])
        else $error("normal mode wrap or overflow wrong");

    a_ctc_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.wgm == `TC8_WGM_CTC && tick && matchA && !wrCnt) |=> (stReg.cnt == `TC8_BOTTOM))
        else $error("ctc did not clear on match a");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (wrClr[`TC8_BIT_MA] && !setA) |=> !stReg.flags[`TC8_BIT_MA])
        else $error("write one did not clear flag a");

    a_irq_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.flags[`TC8_BIT_OVF] && !stReg.mask[`TC8_BIT_OVF]) |-> !irqReq[`TC8_BIT_OVF])
        else $error("masked overflow raised request");

    a_buffer_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isPwm && !(tick && atTop) && !(regWr && regAddr == `TC8_OFF_CTRLA)) |=> $stable(stReg.actA))
        else $error("active compare changed off top");

    // flag side: hardware set, service clear and zero writes
    a_flag_b_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (tick && matchB && !stReg.block) |=> stReg.flags[`TC8_BIT_MB])
        else $error("match b flag not set");

    a_ack_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (intAck[`TC8_BIT_MA] && !setA) |=> !stReg.flags[`TC8_BIT_MA])
        else $error("service pulse did not clear flag a");

    a_irq_enabled: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.flags[`TC8_BIT_MA] && stReg.mask[`TC8_BIT_MA]) |-> irqReq[`TC8_BIT_MA])
        else $error("enabled flag a raised no request");

    a_zero_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regWr && regAddr == `TC8_OFF_FLAG && !regWdata[`TC8_BIT_OVF] && !intAck[`TC8_BIT_OVF]
         && stReg.flags[`TC8_BIT_OVF]) |=> stReg.flags[`TC8_BIT_OVF])
        else $error("zero write disturbed overflow flag");

    // compare paths: direct in non-pwm, buffered and loaded at top in pwm
    a_direct_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!isPwm && regWr && regAddr == `TC8_OFF_CMPA) |=> (stReg.actA == $past(regWdata)))
        else $error("direct compare write did not land");

    a_buffer_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isPwm && regWr && regAddr == `TC8_OFF_CMPA && !(tick && atTop))
        |=> (stReg.bufA == $past(regWdata)) && $stable(stReg.actA))
        else $error("buffered compare write reached active value");

    a_top_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isPwm && tick && atTop) |=> (stReg.actA == $past(stReg.bufA)))
        else $error("buffer not loaded at top");

    // force strobe acts on the output only
    a_force_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!isPwm && !tick && regWr && regAddr == `TC8_OFF_CTRLB && regWdata[`TC8_FOCA_BIT]
         && !stReg.flags[`TC8_BIT_MA]) |=> $stable(stReg.cnt) && !stReg.flags[`TC8_BIT_MA])
        else $error("force touched counter or flag");

    a_force_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!isPwm && regWr && regAddr == `TC8_OFF_CTRLB && regWdata[`TC8_FOCA_BIT]
         && stReg.comA == `TC8_COM_CLEAR) |=> !waveOutA)
        else $error("forced clear left output a high");

    a_com_none: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.comA == `TC8_COM_NONE) |=> $stable(waveOutA))
        else $error("output a moved with no action selected");

    // count sequences that the simple checks above do not reach
    a_phase_turn: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isPhase && tick && stReg.dir == tc8_pkg::TC8_UP && atTop && !wrCnt)
        |=> (stReg.dir == tc8_pkg::TC8_DOWN) && (stReg.cnt == $past(stReg.cnt) - `TC8_CNT_ONE))
        else $error("phase correct count did not turn at top");

    a_phase_ovf: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isPhase && tick && stReg.dir == tc8_pkg::TC8_DOWN && stReg.cnt == `TC8_BOTTOM)
        |=> stReg.flags[`TC8_BIT_OVF])
        else $error("phase correct overflow missing at bottom");

    a_fast_ovf: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (isFast && tick && atTop) |=> stReg.flags[`TC8_BIT_OVF])
        else $error("fast pwm overflow missing at top");

    // a quiet synchronised pin means no base tick in async mode
    a_osc_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (stReg.asyncSel && $stable(stReg.oscS2) && !wrCnt) |=> $stable(stReg.cnt))
        else $error("counter moved without oscillator edge");

    a_read_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !regRd |=> (regRdata == `TC8_ZERO8))
        else $error("read data outside its cycle");

    a_cnt_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (regRd && regAddr == `TC8_OFF_CNT) |=> (regRdata == $past(stReg.cnt)))
        else $error("counter read returned wrong value");
endmodule

// ===== verif/test_tc8_timer.sv
// self-checking bench for the 8-bit timer/counter, one hand-written task per scenario
// assumes tc8_pkg compiled first and the cfg header in the include path
`timescale 1ns/1ps
`include "tc8_cfg.svh"

module test_tc8_timer;
    logic              clk_sys;
    logic              arst_n;
    tc8_pkg::tc8_req_t req;
    logic [2:0]        intAck;
    logic              oscPinIn;
    logic [7:0]        regRdata;
    logic [2:0]        irqReq;
    logic              waveOutA;
    logic              waveOutB;
    int                mismatches;
    int                nCompared;
    int                cycles;
    logic [7:0]        v;

    tc8_timer u_tc8_timer (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .regAddr  (req.addr),
        .regWdata (req.wdata),
        .regWr    (req.wr),
        .regRd    (req.rd),
        .intAck   (intAck),
        .oscPinIn (oscPinIn),
        .regRdata (regRdata),
        .irqReq   (irqReq),
        .waveOutA (waveOutA),
        .waveOutB (waveOutB)
    );

    // ----------------------------------------
    // clock, reset and hang guard
    // ----------------------------------------
    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    // whole run is a few hundred cycles; far above that means a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    // one write cycle, then an idle edge so strobes never toggle twice in a step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = regRdata;
        @(posedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chkReg(input string nm, input logic [3:0] a, input logic [7:0] exp);
        rd(a, v);
        chk(nm, exp, v);
    endtask

    // enable /1 ticks for exactly n edges (n >= 2), stop again
    task automatic run(input int n);
        wr(`TC8_OFF_CTRLB, 8'h01);
        repeat (n - 2) @(posedge clk_sys);
        wr(`TC8_OFF_CTRLB, 8'h00);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 8; a++) chkReg("reset value", 4'(a), 8'h00);
        wr(4'h9, 8'hff);
        chkReg("unmapped read", 4'h9, 8'h00);
        #1 chk("read data after its cycle", 8'h00, regRdata);
    endtask

    task automatic t_stopped();
        wr(`TC8_OFF_CNT, 8'h37);
        repeat (20) @(posedge clk_sys);
        chkReg("counter frozen", `TC8_OFF_CNT, 8'h37);
    endtask

    task automatic t_overflow();
        wr(`TC8_OFF_CMPA, 8'h80);
        wr(`TC8_OFF_CMPB, 8'h90);
        wr(`TC8_OFF_CNT, 8'hfd);
        run(6);
        chkReg("counter after wrap", `TC8_OFF_CNT, 8'h03);
        chkReg("overflow flag", `TC8_OFF_FLAG, 8'h01);
        wr(`TC8_OFF_FLAG, 8'h00);
        chkReg("flag kept on zero write", `TC8_OFF_FLAG, 8'h01);
        wr(`TC8_OFF_FLAG, 8'h01);
        chkReg("flag cleared by one", `TC8_OFF_FLAG, 8'h00);
    endtask

    task automatic t_match_irq();
        wr(`TC8_OFF_CMPA, 8'h10);
        wr(`TC8_OFF_CMPB, 8'h12);
        wr(`TC8_OFF_CNT, 8'h0e);
        run(5);
        chkReg("both matches", `TC8_OFF_FLAG, 8'h06);
        #1 chk("output untouched", 8'h00, {7'h00, waveOutA});
        wr(`TC8_OFF_MASK, 8'h01);
        #1 chk("masked request", 8'h00, {5'h00, irqReq});
        wr(`TC8_OFF_MASK, 8'h02);
        #1 chk("enabled request", 8'h02, {5'h00, irqReq});
        intAck <= 3'b010;
        @(posedge clk_sys);
        intAck <= 3'b000;
        chkReg("flag cleared by service", `TC8_OFF_FLAG, 8'h04);
        #1 chk("request gone", 8'h00, {5'h00, irqReq});
        wr(`TC8_OFF_MASK, 8'h00);
        wr(`TC8_OFF_FLAG, 8'h07);
    endtask

    task automatic t_block();
        wr(`TC8_OFF_CMPA, 8'h20);
        wr(`TC8_OFF_CNT, 8'h20);
        run(2);
        chkReg("match blocked after write", `TC8_OFF_FLAG, 8'h00);
        wr(`TC8_OFF_CNT, 8'h1f);
        run(2);
        chkReg("second tick matches", `TC8_OFF_FLAG, 8'h02);
        wr(`TC8_OFF_FLAG, 8'h07);
    endtask

    task automatic t_priority();
        wr(`TC8_OFF_CTRLB, 8'h01);
        wr(`TC8_OFF_CNT, 8'h12);
        wr(`TC8_OFF_CTRLB, 8'h00);
        chkReg("write beats count", `TC8_OFF_CNT, 8'h14);
        chkReg("running write blocks match b", `TC8_OFF_FLAG, 8'h00);
    endtask

    task automatic t_ctc();
        wr(`TC8_OFF_CTRLA, 8'h42);
        wr(`TC8_OFF_CMPA, 8'h05);
        wr(`TC8_OFF_CNT, 8'h00);
        run(8);
        chkReg("clear at compare a", `TC8_OFF_CNT, 8'h02);
        chkReg("ctc flags", `TC8_OFF_FLAG, 8'h02);
        #1 chk("toggle once", 8'h01, {7'h00, waveOutA});
        wr(`TC8_OFF_FLAG, 8'h07);
    endtask

    task automatic t_force();
        wr(`TC8_OFF_CTRLA, 8'hb0);
        wr(`TC8_OFF_CTRLB, 8'hc0);
        #1 chk("forced clear a", 8'h00, {7'h00, waveOutA});
        chk("forced set b", 8'h01, {7'h00, waveOutB});
        chkReg("force sets no flag", `TC8_OFF_FLAG, 8'h00);
        chkReg("force keeps counter", `TC8_OFF_CNT, 8'h02);
        chkReg("strobes read zero", `TC8_OFF_CTRLB, 8'h00);
    endtask

    task automatic t_pwm_buffer();
        wr(`TC8_OFF_CTRLA, 8'h03);
        wr(`TC8_OFF_CMPA, 8'h40);
        chkReg("buffer read back", `TC8_OFF_CMPA, 8'h40);
        wr(`TC8_OFF_CNT, 8'h3e);
        run(4);
        chkReg("buffer not yet active", `TC8_OFF_FLAG, 8'h00);
        wr(`TC8_OFF_CNT, 8'hfe);
        run(4);
        chkReg("overflow at top", `TC8_OFF_FLAG, 8'h01);
        wr(`TC8_OFF_FLAG, 8'h01);
        wr(`TC8_OFF_CNT, 8'h3f);
        run(3);
        chkReg("loaded at top", `TC8_OFF_FLAG, 8'h02);
        wr(`TC8_OFF_FLAG, 8'h07);
        wr(`TC8_OFF_CTRLA, 8'h00);
    endtask

    // phase correct at fixed top: turns at all ones, overflow only at zero going down
    task automatic t_phase();
        wr(`TC8_OFF_CTRLA, 8'h01);
        wr(`TC8_OFF_CNT, 8'hfd);
        run(6);
        chkReg("phase turn at top", `TC8_OFF_CNT, 8'hfb);
        chkReg("no overflow at top", `TC8_OFF_FLAG, 8'h00);
        wr(`TC8_OFF_CNT, 8'h02);
        run(4);
        chkReg("phase turn at bottom", `TC8_OFF_CNT, 8'h02);
        chkReg("overflow at bottom", `TC8_OFF_FLAG, 8'h01);
        wr(`TC8_OFF_FLAG, 8'h07);
        wr(`TC8_OFF_CTRLA, 8'h00);
    endtask

    // slow oscillator edges, 8 clocks apart, well inside the synchroniser's reach
    task automatic t_async();
        wr(`TC8_OFF_CNT, 8'h00);
        wr(`TC8_OFF_ASYNC, 8'h20);
        chkReg("async select", `TC8_OFF_ASYNC, 8'h20);
        wr(`TC8_OFF_CTRLB, 8'h01);
        repeat (10) @(posedge clk_sys);
        chkReg("no tick without pin", `TC8_OFF_CNT, 8'h00);
        repeat (5) begin
            oscPinIn <= 1'b1;
            repeat (4) @(posedge clk_sys);
            oscPinIn <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        wr(`TC8_OFF_CTRLB, 8'h00);
        chkReg("pin edges counted", `TC8_OFF_CNT, 8'h05);
    endtask

    // ----------------------------------------
    // verdict
    // ----------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clk_sys  = 1'b0;
        arst_n   = 1'b0;
        req      = '0;
        intAck   = 3'b000;
        oscPinIn = 1'b0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_stopped();
        t_overflow();
        t_match_irq();
        t_block();
        t_priority();
        t_ctc();
        t_force();
        t_pwm_buffer();
        t_phase();
        t_async();
        close_out();
    end
endmodule
